//--- hdl/eisp_pkg.sv
/*
 * constants, field layouts and carrier types for the external interrupt
 * sense block of lines a (port a pins 3:0) and f (port f pins 2:0).
 * assumes a classic wishbone master with 32-bit data and byte addresses.
 */
package eisp_pkg;

    localparam int          ADR_W         = 4;
    localparam int          DAT_W         = 32;
    localparam int          PA_W          = 4;
    localparam int          PF_W          = 3;
    localparam int          IRQ_N         = 2;

    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STAT      = 4'h4;
    localparam logic [3:0]  OFS_MASK      = 4'h8;
    localparam logic [3:0]  OFS_PINS      = 4'hC;

    localparam int          CTRL_SENSE_LSB = 3;
    localparam int          CTRL_SENSE_MSB = 4;
    localparam int          CTRL_INV_BIT   = 2;
    localparam int          PEND_A_BIT     = 0;
    localparam int          PEND_F_BIT     = 1;
    localparam int          PINS_F_LSB     = 4;

    localparam logic [1:0]  MASK_LEVEL_3  = 2'h3;
    localparam logic [1:0]  STAT_RESET    = 2'h0;
    localparam logic [1:0]  MASK_RESET    = 2'h0;
    localparam logic [31:0] DAT_ZERO      = 32'h0000_0000;

    typedef enum logic [1:0] {
        SENSE_FALL_LOW = 2'h0,
        SENSE_RISE     = 2'h1,
        SENSE_FALL     = 2'h2,
        SENSE_BOTH     = 2'h3
    } eisp_sense_t;

    typedef struct packed {
        eisp_sense_t sense;
        logic        invert;
    } eisp_ctrl_t;

    localparam eisp_ctrl_t CTRL_RESET = '{sense: SENSE_FALL_LOW, invert: 1'b0};

    typedef struct packed {
        logic [PF_W-1:0] f;
        logic [PA_W-1:0] a;
    } eisp_pins_t;

    typedef struct packed {
        logic fall;
        logic rise;
        logic low;
        logic high;
    } eisp_evt_t;

endpackage : eisp_pkg

//--- hdl/eisp_top.sv
/*
 * external interrupt sense logic for lines a and f with a wishbone
 * register slave, sticky pending bits, a mask and one level interrupt.
 * assumes pins already synchronous to CLK and mask level bits from the core.
 */
`timescale 1ns/100ps
module eisp_top (
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        CYC_I,
    input  wire logic                        STB_I,
    input  wire logic                        WE_I,
    input  wire logic [eisp_pkg::ADR_W-1:0]  ADR_I,
    input  wire logic [3:0]                  SEL_I,
    input  wire logic [eisp_pkg::DAT_W-1:0]  DAT_I,
    output      logic [eisp_pkg::DAT_W-1:0]  DAT_O,
    output      logic                        ACK_O,
    input  wire logic [eisp_pkg::PA_W-1:0]   PORT_A,
    input  wire logic [eisp_pkg::PF_W-1:0]   PORT_F,
    input  wire logic                        MASK_LEVEL_HI,
    input  wire logic                        MASK_LEVEL_LO,
    output      logic                        EXT_IRQ_LINE_A,
    output      logic                        EXT_IRQ_LINE_F,
    output      logic                        IRQ
);

    eisp_pkg::eisp_ctrl_t          ext_irq_control_reg;
    eisp_pkg::eisp_ctrl_t          wr_ctrl;
    eisp_pkg::eisp_pins_t          pins_now;
    eisp_pkg::eisp_pins_t          pins_prev;
    eisp_pkg::eisp_evt_t           evt_a;
    eisp_pkg::eisp_evt_t           evt_f;
    logic                          armed;
    logic [eisp_pkg::IRQ_N-1:0]    status;
    logic [eisp_pkg::IRQ_N-1:0]    mask;
    logic [eisp_pkg::IRQ_N-1:0]    hit;
    logic [eisp_pkg::IRQ_N-1:0]    w1c;
    logic [eisp_pkg::IRQ_N-1:0]    next_status;
    logic                          wb_go;
    logic                          wb_wr;
    logic                          level3;
    logic                          ctrl_wr;
    logic                          cfg_change;
    logic [eisp_pkg::DAT_W-1:0]    next_dat;

    // one trigger decode shared by both lines; line f always passes inv = 0
    function automatic logic sense_hit(
        input eisp_pkg::eisp_sense_t s,
        input logic                  inv,
        input eisp_pkg::eisp_evt_t   e
    );
        case (s)
            eisp_pkg::SENSE_FALL_LOW: begin
                sense_hit = inv ? (e.rise | e.high) : (e.fall | e.low);
            end
            eisp_pkg::SENSE_RISE: begin
                sense_hit = inv ? e.fall : e.rise;
            end
            eisp_pkg::SENSE_FALL: begin
                sense_hit = inv ? e.rise : e.fall;
            end
            default: begin
                sense_hit = e.fall | e.rise;
            end
        endcase
    endfunction : sense_hit

    // any pin of a port may raise its line: edges per pin, level of any pin
    function automatic eisp_pkg::eisp_evt_t pin_events(
        input logic [eisp_pkg::PA_W-1:0] cur,
        input logic [eisp_pkg::PA_W-1:0] prev,
        input logic [eisp_pkg::PA_W-1:0] used,
        input logic                      ok
    );
        pin_events.fall = ok & |(used & prev & ~cur);
        pin_events.rise = ok & |(used & ~prev & cur);
        pin_events.low  = |(used & ~cur);
        pin_events.high = |(used & cur);
    endfunction : pin_events

    assign pins_now = '{f: PORT_F, a: PORT_A};
    assign wb_go    = CYC_I & STB_I & ~ACK_O;
    assign wb_wr    = wb_go & WE_I;
    assign level3   = ({MASK_LEVEL_HI, MASK_LEVEL_LO} == eisp_pkg::MASK_LEVEL_3);

    assign wr_ctrl.sense  = eisp_pkg::eisp_sense_t'(
                            DAT_I[eisp_pkg::CTRL_SENSE_MSB:eisp_pkg::CTRL_SENSE_LSB]);
    assign wr_ctrl.invert = DAT_I[eisp_pkg::CTRL_INV_BIT];
    // a write outside level 3 is acknowledged but leaves the field alone
    assign ctrl_wr    = wb_wr & (ADR_I == eisp_pkg::OFS_CTRL) & SEL_I[0] & level3;
    assign cfg_change = ctrl_wr & (wr_ctrl != ext_irq_control_reg);

    // edges are held off until one real sample exists, so reset looks like no edge
    assign evt_a = pin_events(pins_now.a, pins_prev.a, {eisp_pkg::PA_W{1'b1}}, armed);
    assign evt_f = pin_events({1'b0, pins_now.f}, {1'b0, pins_prev.f},
                              {1'b0, {eisp_pkg::PF_W{1'b1}}}, armed);

    assign hit[eisp_pkg::PEND_A_BIT] = sense_hit(ext_irq_control_reg.sense,
                                                 ext_irq_control_reg.invert, evt_a);
    assign hit[eisp_pkg::PEND_F_BIT] = sense_hit(ext_irq_control_reg.sense,
                                                 1'b0, evt_f);

    assign w1c = (wb_wr & (ADR_I == eisp_pkg::OFS_STAT) & SEL_I[0])
               ? DAT_I[eisp_pkg::IRQ_N-1:0] : '0;

    // a new event in the clearing cycle survives: set is or-ed in last
    assign next_status = (status & ~w1c & ~{eisp_pkg::IRQ_N{cfg_change}}) | hit;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pins_prev <= '0;
            armed     <= 1'b0;
        end else begin
            pins_prev <= pins_now;
            armed     <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_irq_control_reg <= eisp_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ext_irq_control_reg <= wr_ctrl;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask <= eisp_pkg::MASK_RESET;
        end else if (wb_wr && ADR_I == eisp_pkg::OFS_MASK && SEL_I[0]) begin
            mask <= DAT_I[eisp_pkg::IRQ_N-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status         <= eisp_pkg::STAT_RESET;
            EXT_IRQ_LINE_A <= 1'b0;
            EXT_IRQ_LINE_F <= 1'b0;
            IRQ            <= 1'b0;
        end else begin
            status         <= next_status;
            EXT_IRQ_LINE_A <= next_status[eisp_pkg::PEND_A_BIT];
            EXT_IRQ_LINE_F <= next_status[eisp_pkg::PEND_F_BIT];
            IRQ            <= |(next_status & mask);
        end
    end

    always_comb begin
        next_dat = eisp_pkg::DAT_ZERO;
        if (ADR_I == eisp_pkg::OFS_CTRL) begin
            next_dat[eisp_pkg::CTRL_SENSE_MSB:eisp_pkg::CTRL_SENSE_LSB] =
                ext_irq_control_reg.sense;
            next_dat[eisp_pkg::CTRL_INV_BIT] = ext_irq_control_reg.invert;
        end else if (ADR_I == eisp_pkg::OFS_STAT) begin
            next_dat[eisp_pkg::IRQ_N-1:0] = status;
        end else if (ADR_I == eisp_pkg::OFS_MASK) begin
            next_dat[eisp_pkg::IRQ_N-1:0] = mask;
        end else if (ADR_I == eisp_pkg::OFS_PINS) begin
            next_dat[eisp_pkg::PA_W-1:0] = pins_now.a;
            next_dat[eisp_pkg::PINS_F_LSB +: eisp_pkg::PF_W] = pins_now.f;
        end
    end

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACK_O <= 1'b0;
            DAT_O <= eisp_pkg::DAT_ZERO;
        end else begin
            ACK_O <= wb_go;
            if (wb_go && !WE_I) begin
                DAT_O <= next_dat;
            end
        end
    end

endmodule : eisp_top

//--- sim/eisp_pins.sv
/* pin model of ports a and f driven by the outside world.
   assumes the bench hands it the wanted levels; pins move just after an edge. */
`timescale 1ns/100ps
module eisp_pins (
    input  wire logic       CLK,
    input  wire logic [6:0] want,
    output      logic [3:0] pa,
    output      logic [2:0] pf
);
    // registered so every pin move is already synchronous to CLK
    always_ff @(posedge CLK) {pf, pa} <= want;
endmodule : eisp_pins

//--- sim/eisp_top_sva.sv
/* checker for eisp_top: bus answer and pin-to-pending relations.
   assumes one clock and pins synchronous to it. */
`timescale 1ns/100ps
module eisp_top_sva (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [3:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic [3:0]  PORT_A,
    input wire logic [2:0]  PORT_F,
    input wire logic        MASK_LEVEL_HI,
    input wire logic        MASK_LEVEL_LO,
    input wire logic        EXT_IRQ_LINE_A,
    input wire logic        EXT_IRQ_LINE_F,
    input wire logic        IRQ
);
    logic [2:0] ctl;
    logic [3:0] pa_q;
    logic [2:0] pf_q;
    logic       armed;
    wire        take = CYC_I & STB_I & ~ACK_O;
    wire        cw = take & WE_I & ADR_I == 4'h0 & SEL_I[0] & MASK_LEVEL_HI & MASK_LEVEL_LO;
    wire        fa = armed & |(pa_q & ~PORT_A);
    wire        ra = armed & |(~pa_q & PORT_A);
    wire        f_fall = armed & |(pf_q & ~PORT_F);
    wire        f_edge = armed & (pf_q != PORT_F);
    // shadow of the control field, kept only through accepted writes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl   <= 3'h0;
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
            if (cw) begin
                ctl <= DAT_I[4:2];
            end
        end
    end
    always_ff @(posedge CLK) begin
        pa_q <= PORT_A;
        pf_q <= PORT_F;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    a_ack_answer: assert property (take |=> ACK_O) else $error("no ack");
    a_a_rise: assert property (ra && ctl == 3'h2 |=> EXT_IRQ_LINE_A) else $error("a rise");
    a_a_fall: assert property (fa && ctl == 3'h4 |=> EXT_IRQ_LINE_A) else $error("a fall");
    a_a_low: assert property (ctl == 3'h0 && !(&PORT_A) |=> EXT_IRQ_LINE_A) else $error("a low");
    a_a_high: assert property (ctl == 3'h1 && |PORT_A |=> EXT_IRQ_LINE_A) else $error("a inv");
    a_f_both: assert property (f_edge && ctl[2:1] == 2'h3 |=> EXT_IRQ_LINE_F) else $error("f");
    a_f_noinv: assert property (f_fall && ctl == 3'h5 |=> EXT_IRQ_LINE_F) else $error("f inv");
    a_cfg_clear:
        assert property (cw && DAT_I[4:2] != ctl && ctl[2:1] != 2'h0 && !fa && !ra && !f_edge
            |=> !EXT_IRQ_LINE_A && !EXT_IRQ_LINE_F) else $error("pending not cleared");
    a_ctl_read:
        assert property (take && !WE_I && ADR_I == 4'h0 |=> DAT_O[4:2] == ctl) else $error("ctl");
endmodule : eisp_top_sva
bind eisp_top eisp_top_sva eisp_top_sva_inst (.CLK(CLK), .RESET_N(RESET_N), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .PORT_A(PORT_A), .PORT_F(PORT_F), .MASK_LEVEL_HI(MASK_LEVEL_HI),
    .MASK_LEVEL_LO(MASK_LEVEL_LO), .EXT_IRQ_LINE_A(EXT_IRQ_LINE_A),
    .EXT_IRQ_LINE_F(EXT_IRQ_LINE_F), .IRQ(IRQ));

//--- sim/eisp_top_bench.sv
/* bench for eisp_top: every sense code and inversion with random pin moves.
   assumes the pin model and the checker are compiled before it. */
`timescale 1ns/100ps
module eisp_top_bench;
    logic        CLK, RESET_N, CYC_I, STB_I, WE_I, MASK_LEVEL_HI, MASK_LEVEL_LO;
    logic        ACK_O, EXT_IRQ_LINE_A, EXT_IRQ_LINE_F, IRQ;
    logic [3:0]  ADR_I, SEL_I, PORT_A;
    logic [31:0] DAT_I, DAT_O;
    logic [2:0]  PORT_F, c;
    logic [6:0]  want, p, q;
    logic [1:0]  m, e;
    logic [33:0] x, expq[$];
    int          miscompares = 0, check_count = 0, seed = 32'hE0EF;
    eisp_top eisp_top_inst (.CLK(CLK), .RESET_N(RESET_N), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .PORT_A(PORT_A), .PORT_F(PORT_F), .MASK_LEVEL_HI(MASK_LEVEL_HI),
        .MASK_LEVEL_LO(MASK_LEVEL_LO), .EXT_IRQ_LINE_A(EXT_IRQ_LINE_A),
        .EXT_IRQ_LINE_F(EXT_IRQ_LINE_F), .IRQ(IRQ));
    eisp_pins eisp_pins_inst (.CLK(CLK), .want(want), .pa(PORT_A), .pf(PORT_F));
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // events {fall, rise, low, high}; k marks pins that do not exist
    function automatic logic [3:0] ev(input logic [3:0] a, b, k);
        return {|(a & ~b), |(~a & b), ~&(a | k) | ~&(b | k), |(a & ~k) | |(b & ~k)};
    endfunction : ev
    function automatic logic hit(input logic [2:0] cs, input logic [3:0] v);
        if (cs[0]) v = {v[2], v[3], v[0], v[1]};
        case (cs[2:1])
            2'h0: return v[3] | v[1];
            2'h1: return v[2];
            2'h2: return v[3];
            default: return v[3] | v[2];
        endcase
    endfunction : hit
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'h3, w, a, d};
        do @(posedge CLK); while (ACK_O !== 1'b1 && ++n < 100);
        {CYC_I, STB_I} <= 2'h0;
        @(posedge CLK);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [33:0] v);
        expq.push_back(v);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    // read answers are matched in order against the notes left by the driver
    always @(posedge CLK) begin
        if (ACK_O === 1'b1 && WE_I === 1'b0 && expq.size() > 0) begin
            x = expq.pop_front();
            check_count++;
            if (DAT_O !== x[31:0] || (x[33] && IRQ !== x[32])) begin
                miscompares++;
                $display("wrong value at %h: expected %h/%b seen %h/%b", ADR_I, x[31:0], x[32],
                    DAT_O, IRQ);
            end
        end
    end
    initial begin
        {RESET_N, CYC_I, STB_I, WE_I, MASK_LEVEL_HI, MASK_LEVEL_LO, ADR_I, DAT_I, want} = '0;
        SEL_I = 4'hF;
        repeat (12) @(posedge CLK);
        RESET_N <= 1'b1;
        {MASK_LEVEL_HI, MASK_LEVEL_LO} <= 2'h3;
        @(posedge CLK);
        for (int i = 0; i < 32; i++) begin
            c = 3'(i);
            p = 7'($random(seed));
            q = 7'($random(seed));
            m = 2'($random(seed));
            want <= p;
            repeat (3) @(posedge CLK);
            bus(1'b1, 4'h0, {27'h0, c, 2'h0});
            bus(1'b1, 4'h8, {30'h0, m});
            bus(1'b1, 4'h4, 32'h3);
            want <= q;
            repeat (3) @(posedge CLK);
            e = {hit({c[2:1], 1'b0}, ev({1'b0, p[6:4]}, {1'b0, q[6:4]}, 4'h8)),
                 hit(c, ev(p[3:0], q[3:0], 4'h0))};
            rd(4'h4, {1'b1, |(e & m), 30'h0, e});
            rd(4'h0, {29'h0, c, 2'h0});
            $display("sense test %0d done", i);
        end
        // level below 3: the control write must be ignored
        {MASK_LEVEL_HI, MASK_LEVEL_LO} <= 2'h1;
        bus(1'b1, 4'h0, 32'h0);
        rd(4'h0, {29'h0, c, 2'h0});
        rd(4'h2, 34'h0);
        rd(4'hC, {27'h0, q});
        $display("refusal and map test done");
        end_sim();
    end
    initial begin
        #(40 * 4000);
        miscompares++;
        end_sim();
    end
endmodule : eisp_top_bench
